// file: core/msi_pkg.sv
// Package for the magnet supply setpoint and interlock block.
// Assumes a 100 MHz aclk; values are fixed-point counts chosen by the registers.
package msi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SETPOINT  = 8'h04;
  localparam logic [7:0] OFS_RAMP      = 8'h08;
  localparam logic [7:0] OFS_MAX_CUR   = 8'h0C;
  localparam logic [7:0] OFS_MAX_RAMP  = 8'h10;
  localparam logic [7:0] OFS_MODE      = 8'h14;
  localparam logic [7:0] OFS_LOCK      = 8'h18;
  localparam logic [7:0] OFS_CODE      = 8'h1C;
  localparam logic [7:0] OFS_POWER     = 8'h20;
  localparam logic [7:0] OFS_STATUS    = 8'h24;
  localparam logic [7:0] OFS_CUR_OUT   = 8'h28;
  localparam logic [7:0] OFS_ERR       = 8'h2C;

  // Current in 0.1 mA units, ramp rate in 0.1 mA/s units, power in watts
  localparam logic [31:0] CUR_LIMIT_TOP = 32'h000AB248; // 70.1000 A
  localparam logic [31:0] CUR_NOMINAL   = 32'h000AAE60; // 70.0000 A
  localparam logic [31:0] RAMP_MIN      = 32'h00000001; // 0.0001 A/s
  localparam logic [31:0] RAMP_MAX      = 32'h000F4236; // 99.999 A/s
  localparam logic [15:0] POWER_THRESH  = 16'h0064;     // 100 W
  localparam logic [11:0] CODE_DEFAULT  = 12'h123;
  localparam logic [15:0] EXT_FULL_MV   = 16'h2710;     // 10 V full scale

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned HOLD_S        = 60;
  localparam int unsigned PRESC_CYC     = CLK_HZ / 1000; // 1 ms tick
  localparam int unsigned HOLD_TICKS    = HOLD_S * 1000;
  localparam int unsigned BLINK_TICKS   = 500;

  // Error codes, reported in the error register
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_RANGE   = 4'h1;
  localparam logic [3:0] ERR_MODE    = 4'h2;
  localparam logic [3:0] ERR_LOCKED  = 4'h3;
  localparam logic [3:0] ERR_CODE    = 4'h4;
  localparam logic [3:0] ERR_EXTPROG = 4'h5;

  typedef enum logic [1:0] {
    VM_AUTO = 2'b00, VM_ON = 2'b01, VM_OFF = 2'b10, VM_DIS = 2'b11
  } msi_vmode_e;

  typedef enum logic [1:0] {
    PM_INT = 2'b00, PM_EXT = 2'b01, PM_SUM = 2'b10
  } msi_pmode_e;

  typedef enum logic [1:0] {
    LK_NONE = 2'b00, LK_ALL = 2'b01, LK_LIMITS = 2'b10
  } msi_lock_e;

  typedef struct packed {
    logic        energized;
    logic [16:0] hold;
  } msi_valve_s;

  typedef struct packed {
    logic [31:0] setpoint;
    logic [31:0] ramp;
    logic [31:0] max_cur;
    logic [31:0] max_ramp;
    logic [31:0] cur_out;
    msi_pmode_e  pmode;
    msi_lock_e   lock;
    logic [11:0] code;
    msi_vmode_e  vm_mag;
    msi_vmode_e  vm_int;
    logic [15:0] pwr_mag;
    logic [15:0] pwr_int;
    logic [3:0]  err;
    logic        err_show;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [16:0] presc;
    logic        tick;
    logic [9:0]  blink_cnt;
    logic        blink;
    msi_valve_s  vmag;
    msi_valve_s  vint;
    logic [1:0]  ext_zero_s;
    logic [1:0]  flow_mag_s;
    logic [1:0]  flow_int_s;
    logic [1:0]  hw_fault_s;
  } msi_state_s;

endpackage : msi_pkg

// file: core/msi_top.sv
// Setpoint, limits, program mode, cooling valves, fault lamp and keypad lock.
// Assumes AXI4-Lite master on aclk; pins arrive asynchronously; all but ext_prog_cur are synchronised.
// Overview of operation
// - Zero-output command clears setpoint and ramps down, allowed in external mode.
// - Setpoint magnitude above the max-current limit is rejected; limit up to 70.1 A.
// - Entered ramp rate is capped at the max ramp limit.
// - Max ramp limit accepted only within 0.0001 to 99.999 A/s.
// - Auto mode energizes the magnet valve above 100 W.
// - After power falls below threshold, valve stays on one more minute.
// - Forced-on energizes valve while powered; off keeps it released.
// - Disabled mode treats valve as absent and hides its status line.
// - Flow switch checked while valve energized, and always when disabled.
// - Internal valve behaves alike on device power and defaults to disabled.
// - Fault lamp blinks for operational errors, steady for hardware errors.
// - Active error alternates with status prompt; status shows detail or none.
// - External mode forces setpoint zero; output from voltage, 10 V to 70 A.
// - Summed mode drives output from internal setpoint plus external value.
// - Stored limits do not apply to the external contribution.
// - Mode change refused unless voltage and setpoint are zero; error shown.
// - Lock-all blocks setpoint, ramp, limit and mode changes; lock-limits still allows setpoint and ramp; zero always allowed.
// - Three-digit code, default 123, set only by computer, reset with defaults.
// - Locked keypad refuses restore-defaults requests.
// - Locked keypad allows viewing; blocked change shows locked message.
// - New lock mode applies only when entered code matches, else invalid code.
`timescale 1ns/1ns
module msi_top #(
  parameter int unsigned HOLD_T  = msi_pkg::HOLD_TICKS,
  parameter int unsigned PRESC_T = msi_pkg::PRESC_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] ext_prog_cur,
  input  wire logic        ext_volt_zero,
  input  wire logic        flow_ok_mag,
  input  wire logic        flow_ok_int,
  input  wire logic        hw_fault,
  output logic             valve_mag,
  output logic             valve_int,
  output logic             show_mag_line,
  output logic             show_int_line,
  output logic             flow_fault_mag,
  output logic             flow_fault_int,
  output logic             fault_lamp,
  output logic             prompt_phase,
  output logic [31:0]      cur_cmd
);

  msi_pkg::msi_state_s s_r;
  msi_pkg::msi_state_s s_nxt;

  logic        wr_go;
  logic        rd_go;
  logic [31:0] wd;
  logic        lock_any;
  logic        ext_zero;
  logic [31:0] abs_wd;

  assign wr_go    = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign rd_go    = s_axi_arvalid && !s_r.rvalid;
  assign wd       = s_r.wdata;
  assign abs_wd   = wd[31] ? (~wd + 32'h00000001) : wd;
  assign lock_any = (s_r.lock != msi_pkg::LK_NONE);
  assign ext_zero = s_r.ext_zero_s[1];

  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready  = !s_r.w_got;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  function automatic msi_pkg::msi_valve_s valve_step(
    input msi_pkg::msi_vmode_e m,
    input logic [15:0]         pwr,
    input msi_pkg::msi_valve_s v,
    input logic                tick,
    input logic [16:0]         hold_t
  );
    msi_pkg::msi_valve_s o;
    o = v;
    case (m)
      msi_pkg::VM_AUTO:
      begin
        if (pwr > msi_pkg::POWER_THRESH)
        begin
          o.energized = 1'b1;
          o.hold      = hold_t;
        end
        else if (v.hold != 17'h00000)
        begin
          if (tick)
            o.hold = v.hold - 17'h00001;
        end
        else
          o.energized = 1'b0;
      end
      msi_pkg::VM_ON:
      begin
        o.energized = 1'b1;
        o.hold      = 17'h00000;
      end
      default:
      begin
        o.energized = 1'b0;
        o.hold      = 17'h00000;
      end
    endcase
    return o;
  endfunction : valve_step

  always_comb
  begin
    s_nxt            = s_r;
    s_nxt.ext_zero_s = {s_r.ext_zero_s[0], ext_volt_zero};
    s_nxt.flow_mag_s = {s_r.flow_mag_s[0], flow_ok_mag};
    s_nxt.flow_int_s = {s_r.flow_int_s[0], flow_ok_int};
    s_nxt.hw_fault_s = {s_r.hw_fault_s[0], hw_fault};

    // Prescaler and blink timebase
    s_nxt.tick = 1'b0;
    if (s_r.presc >= 17'(PRESC_T - 1))
    begin
      s_nxt.presc = 17'h00000;
      s_nxt.tick  = 1'b1;
    end
    else
      s_nxt.presc = s_r.presc + 17'h00001;
    if (s_r.tick)
    begin
      if (s_r.blink_cnt >= 10'(msi_pkg::BLINK_TICKS - 1))
      begin
        s_nxt.blink_cnt = 10'h000;
        s_nxt.blink     = !s_r.blink;
      end
      else
        s_nxt.blink_cnt = s_r.blink_cnt + 10'h001;
    end

    s_nxt.vmag = valve_step(s_r.vm_mag, s_r.pwr_mag, s_r.vmag, s_r.tick, 17'(HOLD_T));
    s_nxt.vint = valve_step(s_r.vm_int, s_r.pwr_int, s_r.vint, s_r.tick, 17'(HOLD_T));

    // External mode pins the panel setpoint at zero
    if (s_r.pmode == msi_pkg::PM_EXT)
      s_nxt.setpoint = 32'h00000000;

    // Internal ramp toward setpoint, one rate step per ms tick
    if (s_r.tick)
    begin
      if ($signed(s_r.cur_out) < $signed(s_r.setpoint))
        s_nxt.cur_out = ($signed(s_r.setpoint - s_r.cur_out) > $signed(s_r.ramp / 1000))
                        ? s_r.cur_out + (s_r.ramp / 1000) + 32'h00000001 : s_r.setpoint;
      else if ($signed(s_r.cur_out) > $signed(s_r.setpoint))
        s_nxt.cur_out = ($signed(s_r.cur_out - s_r.setpoint) > $signed(s_r.ramp / 1000))
                        ? s_r.cur_out - (s_r.ramp / 1000) - 32'h00000001 : s_r.setpoint;
    end

    // Write channel
    if (s_axi_awvalid && !s_r.aw_got)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (wr_go)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = 2'b00;
      case (s_r.awaddr)
        msi_pkg::OFS_CTRL:
        begin
          if (wd[0])
            s_nxt.setpoint = 32'h00000000;
          if (wd[1])
          begin
            if (lock_any)
              s_nxt.err = msi_pkg::ERR_LOCKED;
            else
            begin
              s_nxt.max_cur  = msi_pkg::CUR_LIMIT_TOP;
              s_nxt.max_ramp = msi_pkg::RAMP_MAX;
              s_nxt.ramp     = msi_pkg::RAMP_MAX;
              s_nxt.setpoint = 32'h00000000;
              s_nxt.pmode    = msi_pkg::PM_INT;
              s_nxt.code     = msi_pkg::CODE_DEFAULT;
              s_nxt.vm_mag   = msi_pkg::VM_AUTO;
              s_nxt.vm_int   = msi_pkg::VM_DIS;
            end
          end
          if (wd[2])
            s_nxt.err_show = 1'b1;
          if (wd[3])
          begin
            s_nxt.err      = msi_pkg::ERR_NONE;
            s_nxt.err_show = 1'b0;
          end
        end
        msi_pkg::OFS_SETPOINT:
        begin
          if (s_r.lock == msi_pkg::LK_ALL)
            s_nxt.err = msi_pkg::ERR_LOCKED;
          else if (s_r.pmode == msi_pkg::PM_EXT)
            s_nxt.err = msi_pkg::ERR_EXTPROG;
          else if (abs_wd > s_r.max_cur)
            s_nxt.err = msi_pkg::ERR_RANGE;
          else
            s_nxt.setpoint = wd;
        end
        msi_pkg::OFS_RAMP:
        begin
          if (s_r.lock == msi_pkg::LK_ALL)
            s_nxt.err = msi_pkg::ERR_LOCKED;
          else
            s_nxt.ramp = (wd > s_r.max_ramp) ? s_r.max_ramp : wd;
        end
        msi_pkg::OFS_MAX_CUR:
        begin
          if (lock_any)
            s_nxt.err = msi_pkg::ERR_LOCKED;
          else if (wd > msi_pkg::CUR_LIMIT_TOP)
            s_nxt.err = msi_pkg::ERR_RANGE;
          else
            s_nxt.max_cur = wd;
        end
        msi_pkg::OFS_MAX_RAMP:
        begin
          if (lock_any)
            s_nxt.err = msi_pkg::ERR_LOCKED;
          else if (wd < msi_pkg::RAMP_MIN || wd > msi_pkg::RAMP_MAX)
            s_nxt.err = msi_pkg::ERR_RANGE;
          else
          begin
            s_nxt.max_ramp = wd;
            if (s_r.ramp > wd)
              s_nxt.ramp = wd;
          end
        end
        msi_pkg::OFS_MODE:
        begin
          if (lock_any)
            s_nxt.err = msi_pkg::ERR_LOCKED;
          else
          begin
            s_nxt.vm_mag = msi_pkg::msi_vmode_e'(wd[5:4]);
            s_nxt.vm_int = msi_pkg::msi_vmode_e'(wd[9:8]);
            if (wd[1:0] != s_r.pmode && wd[1:0] != 2'b11)
            begin
              if (!ext_zero || s_r.setpoint != 32'h00000000)
                s_nxt.err = msi_pkg::ERR_MODE;
              else
                s_nxt.pmode = msi_pkg::msi_pmode_e'(wd[1:0]);
            end
          end
        end
        msi_pkg::OFS_LOCK:
        begin
          if (wd[15:4] == s_r.code && wd[1:0] != 2'b11)
            s_nxt.lock = msi_pkg::msi_lock_e'(wd[1:0]);
          else
            s_nxt.err = msi_pkg::ERR_CODE;
        end
        msi_pkg::OFS_CODE:
          s_nxt.code = wd[11:0];
        msi_pkg::OFS_POWER:
        begin
          s_nxt.pwr_mag = wd[15:0];
          s_nxt.pwr_int = wd[31:16];
        end
        default:
          s_nxt.bresp = 2'b10;
      endcase
    end

    // Read channel
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (rd_go)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = 2'b00;
      case (s_axi_araddr)
        msi_pkg::OFS_SETPOINT: s_nxt.rdata = s_r.setpoint;
        msi_pkg::OFS_RAMP:     s_nxt.rdata = s_r.ramp;
        msi_pkg::OFS_MAX_CUR:  s_nxt.rdata = s_r.max_cur;
        msi_pkg::OFS_MAX_RAMP: s_nxt.rdata = s_r.max_ramp;
        msi_pkg::OFS_MODE:     s_nxt.rdata = {22'h0, s_r.vm_int, 2'b00, s_r.vm_mag,
                                              2'b00, s_r.pmode};
        msi_pkg::OFS_LOCK:     s_nxt.rdata = {30'h0, s_r.lock};
        msi_pkg::OFS_CODE:     s_nxt.rdata = {20'h0, s_r.code};
        msi_pkg::OFS_POWER:    s_nxt.rdata = {s_r.pwr_int, s_r.pwr_mag};
        msi_pkg::OFS_STATUS:   s_nxt.rdata = {25'h0, fault_lamp, flow_fault_int,
                                              flow_fault_mag, s_r.vint.energized,
                                              s_r.vmag.energized, show_int_line,
                                              show_mag_line};
        msi_pkg::OFS_CUR_OUT:  s_nxt.rdata = cur_cmd;
        msi_pkg::OFS_ERR:      s_nxt.rdata = {26'h0, prompt_phase, s_r.err_show, s_r.err};
        msi_pkg::OFS_CTRL:     s_nxt.rdata = 32'h00000000;
        default:
        begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r          <= '0;
      s_r.max_cur  <= msi_pkg::CUR_LIMIT_TOP;
      s_r.max_ramp <= msi_pkg::RAMP_MAX;
      s_r.ramp     <= msi_pkg::RAMP_MAX;
      s_r.code     <= msi_pkg::CODE_DEFAULT;
      s_r.vm_mag   <= msi_pkg::VM_AUTO;
      s_r.vm_int   <= msi_pkg::VM_DIS;
      s_r.ext_zero_s <= 2'b11;
      s_r.flow_mag_s <= 2'b11;
      s_r.flow_int_s <= 2'b11;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs; summed mode adds unlimited external current
  always_comb
  begin
    case (s_r.pmode)
      msi_pkg::PM_EXT: cur_cmd = ext_prog_cur;
      msi_pkg::PM_SUM: cur_cmd = s_r.cur_out + ext_prog_cur;
      default:         cur_cmd = s_r.cur_out;
    endcase
  end

  assign valve_mag      = s_r.vmag.energized;
  assign valve_int      = s_r.vint.energized;
  assign show_mag_line  = (s_r.vm_mag != msi_pkg::VM_DIS);
  assign show_int_line  = (s_r.vm_int != msi_pkg::VM_DIS);
  assign flow_fault_mag = !s_r.flow_mag_s[1] &&
                          (s_r.vmag.energized || s_r.vm_mag == msi_pkg::VM_DIS);
  assign flow_fault_int = !s_r.flow_int_s[1] &&
                          (s_r.vint.energized || s_r.vm_int == msi_pkg::VM_DIS);
  // Hardware fault steady wins over blinking operational fault
  assign fault_lamp     = s_r.hw_fault_s[1] ||
                          ((s_r.err != msi_pkg::ERR_NONE || flow_fault_mag || flow_fault_int)
                           && s_r.blink);
  assign prompt_phase   = (s_r.err != msi_pkg::ERR_NONE) && s_r.blink;

  a_zero_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && s_r.awaddr == msi_pkg::OFS_CTRL && wd[0]) |=> s_r.setpoint == 32'h0)
    else $error("zero command did not clear setpoint");
  a_ramp_capped: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.ramp <= s_r.max_ramp) else $error("ramp above limit");
  a_maxramp_range: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.max_ramp >= msi_pkg::RAMP_MIN && s_r.max_ramp <= msi_pkg::RAMP_MAX)
    else $error("max ramp out of range");
  a_valve_auto_on: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.vm_mag == msi_pkg::VM_AUTO && s_r.pwr_mag > msi_pkg::POWER_THRESH
     && $stable(s_r.vm_mag)) |=> valve_mag) else $error("magnet valve not energized");
  a_valve_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.vm_mag == msi_pkg::VM_OFF) |=> (!valve_mag || s_r.vm_mag != msi_pkg::VM_OFF))
    else $error("valve energized in off mode");
  a_ext_setpoint: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.pmode == msi_pkg::PM_EXT |=> s_r.setpoint == 32'h0)
    else $error("setpoint nonzero in external mode");
  a_mode_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(s_r.pmode)) |-> ($past(ext_zero) && $past(s_r.setpoint) == 32'h0))
    else $error("program mode changed while not zero");
  a_lock_code: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s_r.lock) |-> $past(wd[15:4]) == $past(s_r.code))
    else $error("lock changed without matching code");
  a_setpoint_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s_r.setpoint) && s_r.setpoint != 32'h0 |->
      (s_r.setpoint[31] ? ~s_r.setpoint + 32'h1 : s_r.setpoint) <= $past(s_r.max_cur))
    else $error("setpoint exceeds max current");

endmodule : msi_top

// file: verif/msi_far_model.sv
// Far side: programming-voltage source, flow switches, hardware fault line.
// Assumes the bench commands volts in millivolts and the other pins as levels.
`timescale 1ns/1ns
module msi_far_model (
  input  wire logic [15:0] mv_cmd,
  input  wire logic        flow_mag_cmd,
  input  wire logic        flow_int_cmd,
  input  wire logic        fault_cmd,
  output logic      [31:0] ext_prog_cur,
  output logic             ext_volt_zero,
  output logic             flow_ok_mag,
  output logic             flow_ok_int,
  output logic             hw_fault
);
  // 10 V makes 70 A: 70 steps of 0.1 mA per millivolt
  always_comb
  begin
    ext_prog_cur  = 32'(mv_cmd) * 32'h00000046;
    ext_volt_zero = (mv_cmd == 16'h0000);
    flow_ok_mag   = flow_mag_cmd;
    flow_ok_int   = flow_int_cmd;
    hw_fault      = fault_cmd;
  end
endmodule : msi_far_model

// file: verif/testbench.sv
// Self-checking bench for the setpoint, valve, fault and lock block.
// Assumes shortened hold parameters; this module is the bus master.
`timescale 1ns/1ns
module testbench;
  localparam int unsigned HOLD_T  = 5;
  localparam int unsigned PRESC_T = 4;
  logic [31:0] s_axi_wdata, s_axi_rdata, ext_prog_cur, cur_cmd, rd;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] mv_cmd;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ext_volt_zero, flow_ok_mag, flow_ok_int, hw_fault, l0, p0;
  logic        valve_mag, valve_int, show_mag_line, show_int_line, flow_fault_mag;
  logic        flow_fault_int, fault_lamp, prompt_phase, flow_mag_cmd, flow_int_cmd, fault_cmd;
  int          error_cnt, num_checks, n, t1, t2;
  // Row: write flag, byte address, data written or word expected back
  localparam logic [40:0] ROWS [52] = '{
    41'h0_0C_000AB248, 41'h0_10_000F4236, 41'h0_08_000F4236, 41'h0_14_00000300,
    41'h0_1C_00000123, 41'h1_10_00000000, 41'h0_10_000F4236, 41'h0_2C_00000001,
    41'h1_10_000F4237, 41'h0_10_000F4236, 41'h1_00_00000008, 41'h0_2C_00000000,
    41'h1_10_00000001, 41'h0_10_00000001, 41'h1_08_00000005, 41'h0_08_00000001,
    41'h1_0C_000AB249, 41'h0_0C_000AB248, 41'h1_0C_000003E8, 41'h1_04_000003E9,
    41'h0_04_00000000, 41'h1_04_FFFFFC17, 41'h0_04_00000000, 41'h0_2C_00000001,
    41'h1_04_000003E8, 41'h0_04_000003E8, 41'h1_00_00000001, 41'h0_04_00000000,
    41'h1_00_00000008, 41'h1_18_00004561, 41'h0_18_00000000, 41'h0_2C_00000004,
    41'h1_18_00001231, 41'h0_18_00000001, 41'h1_04_00000010, 41'h0_04_00000000,
    41'h0_2C_00000003, 41'h1_00_00000002, 41'h0_10_00000001, 41'h1_18_00001232,
    41'h0_18_00000002, 41'h1_04_00000010, 41'h0_04_00000010, 41'h1_10_00000002,
    41'h0_10_00000001, 41'h1_18_00001230, 41'h1_1C_00000456, 41'h1_18_00001231,
    41'h0_18_00000000, 41'h1_00_00000002, 41'h0_1C_00000123, 41'h0_10_000F4236};
  // Valve mode word, then expected valve, flow fault, status line
  localparam logic [15:0] VM [3] = '{16'h0107, 16'h0201, 16'h3302};

  msi_top #(.HOLD_T(HOLD_T), .PRESC_T(PRESC_T)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_prog_cur, .ext_volt_zero, .flow_ok_mag, .flow_ok_int, .hw_fault,
    .valve_mag, .valve_int, .show_mag_line, .show_int_line, .flow_fault_mag, .flow_fault_int,
    .fault_lamp, .prompt_phase, .cur_cmd);
  msi_far_model far (.mv_cmd, .flow_mag_cmd, .flow_int_cmd, .fault_cmd, .ext_prog_cur,
    .ext_volt_zero, .flow_ok_mag, .flow_ok_int, .hw_fault);

  task automatic wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask : check

  task automatic check_bit(input string nm, input logic exp, input logic got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("Error %s expected %b seen %b", nm, exp, got);
      end
    end
  endtask : check_bit

  // Ready and valid are sampled mid-cycle; inputs only move at rising edges
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic aw, w, ar, b, r;
    begin
      b = 1'b0;
      r = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_araddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid  <= wr;
      s_axi_bready  <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready  <= !wr;
      for (int k = 0; k < 300 && !(b || r); k++)
      begin
        @(negedge aclk);
        aw = s_axi_awready;
        w  = s_axi_wready;
        ar = s_axi_arready;
        b  = s_axi_bvalid;
        r  = s_axi_rvalid;
        rd = s_axi_rdata;
        @(posedge aclk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
        if (ar) s_axi_arvalid <= 1'b0;
        if (b) s_axi_bready <= 1'b0;
        if (r) s_axi_rready <= 1'b0;
      end
      if (!(b || r)) error_cnt++;
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    begin
      bus(1'b0, a, 32'h00000000);
      check($sformatf("reg %h", a), exp & m, rd & m);
      check("rresp", 32'h00000000, {30'h0, s_axi_rresp});
    end
  endtask : rd_chk

  task automatic wait_cyc(input int k);
    begin
      repeat (k) @(posedge aclk);
      @(negedge aclk);
    end
  endtask : wait_cyc

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, mv_cmd, fault_cmd} = '0;
    s_axi_wstrb = 4'hF;
    {flow_mag_cmd, flow_int_cmd} = 2'b11;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (n = 0; n < 52; n++)
      if (ROWS[n][40]) bus(1'b1, ROWS[n][39:32], ROWS[n][31:0]);
      else rd_chk(ROWS[n][39:32], ROWS[n][31:0], (ROWS[n][39:32] == 8'h2C) ? 32'h0000000F : 32'hFFFFFFFF);
    bus(1'b1, 8'h20, 32'h00000065);
    wait_cyc(4);
    check_bit("valve_mag", 1'b1, valve_mag);
    bus(1'b1, 8'h20, 32'h00000064);
    wait_cyc(8);
    check_bit("valve_mag", 1'b1, valve_mag);
    wait_cyc(40);
    check_bit("valve_mag", 1'b0, valve_mag);
    bus(1'b1, 8'h14, 32'h00000000);
    bus(1'b1, 8'h20, 32'h00650000);
    flow_mag_cmd <= 1'b0;
    wait_cyc(4);
    check_bit("valve_int", 1'b1, valve_int);
    check_bit("show_int_line", 1'b1, show_int_line);
    for (n = 0; n < 3; n++)
    begin
      bus(1'b1, 8'h14, {20'h00000, VM[n][15:4]});
      wait_cyc(6);
      check_bit("valve_mag", VM[n][2], valve_mag);
      check_bit("flow_fault_mag", VM[n][1], flow_fault_mag);
      check_bit("show_mag_line", VM[n][0], show_mag_line);
    end
    check_bit("flow_fault_int", 1'b0, flow_fault_int);
    bus(1'b1, 8'h14, 32'h00000300);
    flow_mag_cmd <= 1'b1;
    mv_cmd <= 16'h0040;
    wait_cyc(6);
    bus(1'b1, 8'h14, 32'h00000301);
    rd_chk(8'h14, 32'h00000300, 32'hFFFFFFFF);
    rd_chk(8'h2C, 32'h00000002, 32'h0000000F);
    mv_cmd <= 16'h0000;
    wait_cyc(6);
    bus(1'b1, 8'h14, 32'h00000301);
    rd_chk(8'h14, 32'h00000301, 32'hFFFFFFFF);
    mv_cmd <= 16'h0040;
    bus(1'b1, 8'h04, 32'h00000010);
    rd_chk(8'h04, 32'h00000000, 32'hFFFFFFFF);
    rd_chk(8'h2C, 32'h00000005, 32'h0000000F);
    wait_cyc(2);
    check("cur_cmd", 32'h00001180, cur_cmd);
    @(posedge aclk);
    mv_cmd <= 16'h0000;
    wait_cyc(6);
    bus(1'b1, 8'h14, 32'h00000302);
    bus(1'b1, 8'h0C, 32'h000003E8);
    bus(1'b1, 8'h04, 32'h000003E8);
    mv_cmd <= 16'h0040;
    wait_cyc(60);
    check("cur_cmd", 32'h00001568, cur_cmd);
    t1 = 0;
    t2 = 0;
    for (n = 0; n < 4200; n++)
    begin
      l0 = fault_lamp;
      p0 = prompt_phase;
      @(negedge aclk);
      t1 += (fault_lamp !== l0);
      t2 += (prompt_phase !== p0);
    end
    check_bit("fault_lamp blink", 1'b1, t1 >= 2 && t1 <= 3);
    check_bit("prompt_phase", 1'b1, t2 > 0);
    bus(1'b1, 8'h00, 32'h00000008);
    bus(1'b1, 8'h00, 32'h00000004);
    rd_chk(8'h2C, 32'h00000010, 32'h0000001F);
    fault_cmd <= 1'b1;
    wait_cyc(6);
    t1 = 0;
    for (n = 0; n < 100; n++)
    begin
      @(negedge aclk);
      t1 += !fault_lamp;
    end
    check_bit("fault_lamp steady", 1'b1, t1 == 0);
    wrap_up();
  end
endmodule : testbench
